/* File: rtl/lsl_pkg.sv */
// Constants and carrier types for the LED shift-and-latch front end
package lsl_pkg;
  localparam int unsigned LSL_WIDTH = 8;
  localparam int unsigned LSL_MSB = 7;
  localparam int unsigned LSL_FAULT_UPPER = 6;
  localparam int unsigned LSL_FAULT_LOWER = 5;
  localparam logic [7:0] LSL_RESET_VAL = 8'h00;
  localparam logic [7:0] LSL_ALL_OFF = 8'h00;

  // Serial control pins as sampled
  typedef struct packed {
    logic ser_in;
    logic ser_clk;
    logic latch_load;
    logic output_disable;
  } lsl_pins_t;

  // One open-drain sink group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } lsl_sink_t;
endpackage : lsl_pkg

/* File: rtl/lsl_top.sv */
// Serial shift register, transparent latch and open-drain sink control
`timescale 1ns/10ps
`default_nettype none
module lsl_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire lsl_pkg::lsl_pins_t pins_i,
  input wire logic [7:0] current_low_i,
  output lsl_pkg::lsl_sink_t sink_o,
  output logic ser_out_o
);
  import lsl_pkg::*;

  // Synchroniser stages for the control pins
  lsl_pins_t meta_q;
  lsl_pins_t sync_q;
  lsl_pins_t prev_q;

  // Synchroniser stages for the sensed-current flags
  logic [7:0] cur_meta_q;
  logic [7:0] cur_sync_q;

  // Pipeline fill marker, keeps false edges out after reset
  logic [2:0] fill_q;
  logic armed;

  // Shift register and its serial output
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic ser_out_q;
  logic ser_out_d;

  // Output latch and registered sink enables
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] oe_q;
  logic [7:0] oe_d;

  // Decoded events and derived words
  logic clk_rise;
  logic load_rise;
  logic load_high;
  logic blank;
  logic open_any;
  logic fault_val;
  logic [7:0] shift_next;
  logic [7:0] fault_word;

  // High on the first synced cycle a level is seen high
  function automatic logic rise_of(input logic now_lvl, input logic was_lvl);
    rise_of = now_lvl & ~was_lvl;
  endfunction : rise_of

  // Any sink requested while its current is sensed low
  function automatic logic open_found(input logic [7:0] req, input logic [7:0] low);
    open_found = |(req & low);
  endfunction : open_found

  // Word moved up one place, new bit at the bottom
  function automatic logic [7:0] shifted_in(input logic [7:0] word, input logic bit_in);
    shifted_in = {word[LSL_MSB-1:0], bit_in};
  endfunction : shifted_in

  // Word with both fault positions set to one status
  function automatic logic [7:0] with_fault(input logic [7:0] word, input logic flag);
    logic [7:0] res;
    res = word;
    res[LSL_FAULT_UPPER] = flag;
    res[LSL_FAULT_LOWER] = flag;
    with_fault = res;
  endfunction : with_fault

  // First synchroniser stage for the control pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
    end else if (ce_i) begin
      meta_q <= pins_i;
    end
  end

  // Second synchroniser stage for the control pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q <= '0;
    end else if (ce_i) begin
      sync_q <= meta_q;
    end
  end

  // Previous synced levels for edge finding
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= '0;
    end else if (ce_i) begin
      prev_q <= sync_q;
    end
  end

  // First synchroniser stage for the current flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_meta_q <= LSL_RESET_VAL;
    end else if (ce_i) begin
      cur_meta_q <= current_low_i;
    end
  end

  // Second synchroniser stage for the current flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_sync_q <= LSL_RESET_VAL;
    end else if (ce_i) begin
      cur_sync_q <= cur_meta_q;
    end
  end

  // Counts the pipeline full before edges are trusted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fill_q <= '0;
    end else if (ce_i) begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // Edges only once the stale reset levels have left
  assign armed = &fill_q;

  // Edge and level decode on synchronised pins only
  assign clk_rise = armed & rise_of(sync_q.ser_clk, prev_q.ser_clk);
  assign load_rise = armed & rise_of(sync_q.latch_load, prev_q.latch_load);
  assign load_high = sync_q.latch_load;
  assign blank = sync_q.output_disable;

  // Open circuit: incoming latch bit asks for current
  assign open_any = open_found(latch_d, cur_sync_q);

  // One status drives both fault positions
  assign fault_val = open_any;

  // Candidate words for the shift register
  assign shift_next = shifted_in(shift_q, sync_q.ser_in);
  assign fault_word = with_fault(shift_q, fault_val);

  // Shift wins over fault insertion on coincident edges
  always_comb begin
    shift_d = shift_q;
    if (clk_rise) begin
      shift_d = shift_next;
    end else if (load_rise) begin
      shift_d = fault_word;
    end
  end

  // Top bit leaves on each serial clock rise
  always_comb begin
    ser_out_d = ser_out_q;
    if (clk_rise) begin
      ser_out_d = shift_q[LSL_MSB];
    end
  end

  // Transparent latch, independent of output_disable
  assign latch_d = load_high ? shift_q : latch_q;

  // Blanking gates only the sinks, never the latch
  assign oe_d = blank ? LSL_ALL_OFF : latch_q;

  // Shift register update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_q <= LSL_RESET_VAL;
    end else if (ce_i) begin
      shift_q <= shift_d;
    end
  end

  // Serial output update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_out_q <= 1'b0;
    end else if (ce_i) begin
      ser_out_q <= ser_out_d;
    end
  end

  // Output latch update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_q <= LSL_RESET_VAL;
    end else if (ce_i) begin
      latch_q <= latch_d;
    end
  end

  // Sink enables from a flop, off at reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_q <= LSL_ALL_OFF;
    end else if (ce_i) begin
      oe_q <= oe_d;
    end
  end

  // Open-drain sinks: pull low when lit and enabled
  assign sink_o.out = LSL_ALL_OFF;
  assign sink_o.oe = oe_q;

  // Serial output pin
  assign ser_out_o = ser_out_q;

endmodule : lsl_top
`default_nettype wire

/* File: bench/lsl_top_assertions.sv */
// Port checker for the shift-and-latch block
`timescale 1ns/10ps
`default_nettype none
module lsl_chk (input wire logic clk_i, rst_b_i, ser_out_o,
  input wire lsl_pkg::lsl_pins_t pins_i, input wire lsl_pkg::lsl_sink_t sink_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence idle_s; !pins_i.ser_clk[*6]; endsequence
  out_low_a: assert property (sink_o.out == 8'h00) else $error("out");
  reset_zero_a: assert property ($rose(rst_b_i) |-> !sink_o.oe && !ser_out_o)
    else $error("rst");
  idle_hold_a: assert property (idle_s |-> $stable(ser_out_o)) else $error("idle");
  rise_delay_a: assert property ($changed(ser_out_o) |-> $past(pins_i.ser_clk, 3)
    && !$past(pins_i.ser_clk, 4)) else $error("rise");
  dout_clk_a: assert property ($changed(ser_out_o) |-> $past(pins_i.ser_clk, 2))
    else $error("dout");
  latch_hold_a: assert property ((!pins_i.latch_load && !pins_i.output_disable)[*6]
    |-> $stable(sink_o.oe)) else $error("latch");
  sink_blank_a: assert property (pins_i.output_disable[*4] |-> !sink_o.oe)
    else $error("blank");
  sink_enable_a: assert property (|sink_o.oe |-> !$past(pins_i.output_disable, 2)
    || !$past(pins_i.output_disable, 3)) else $error("enable");
endmodule : lsl_chk
bind lsl_top lsl_chk u_chk (.clk_i, .rst_b_i, .ser_out_o, .pins_i, .sink_o);
`default_nettype wire

/* File: bench/lsl_host.sv */
// Host model shifting words in and collecting the words shifted out
`timescale 1ns/10ps
`default_nettype none
module lsl_host (input wire logic clk_i, so_i, output logic si_o, sc_o, ld_o,
  output logic [7:0] got_o);
  initial {si_o, sc_o, ld_o, got_o} = 11'h000;
  // One 80 ns serial clock per bit, then a load pulse
  task automatic send(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      got_o <= {got_o[6:0], so_i};
      si_o <= w[i];
      repeat (4) @(posedge clk_i);
      sc_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sc_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    got_o <= {got_o[6:0], so_i};
    ld_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    ld_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : send
endmodule : lsl_host
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the shift-and-latch block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lsl_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, ce = 1'b1, dis = 1'b0, si, sc, ld, so;
  logic [7:0] cl = 8'h00, got, prev, held;
  lsl_sink_t sink;
  int mismatches = 0, check_count = 0;
  // Rows: word, open-sink flags, disable, expected sinks, expected word shifted back
  logic [39:0] rows [5] = '{40'ha5_00_00_85_85, 40'h3c_20_00_7c_7c, 40'hc3_3c_01_00_83,
    40'h00_ff_00_00_00, 40'ha5_00_00_85_85};
  lsl_top u_lsl_top (.clk_i, .rst_b_i, .ce_i(ce), .pins_i({si, sc, ld, dis}),
    .current_low_i(cl), .sink_o(sink), .ser_out_o(so));
  lsl_host u_host (.clk_i, .so_i(so), .si_o(si), .sc_o(sc), .ld_o(ld), .got_o(got));
  task automatic chk(input string n, input logic [7:0] x, y);
    check_count++;
    if (x !== y) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial forever #5 clk_i = ~clk_i;
  initial begin #60000; mismatches++; wrap_up; end
  // Each word is read back while the next one goes in
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    prev = LSL_RESET_VAL;
    foreach (rows[i]) begin
      cl <= rows[i][31:24];
      dis <= rows[i][16];
      u_host.send(rows[i][39:32]);
      chk("dout", prev, got);
      chk("oe", rows[i][15:8], sink.oe);
      prev = rows[i][7:0];
    end
    // Latch still loads while the sinks are blanked
    dis <= 1'b1;
    cl <= 8'h00;
    u_host.send(8'h81);
    chk("dout_blank", prev, got);
    dis <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("blank_load", 8'h81, sink.oe);
    // Nothing moves while the clock enable is low
    held = sink.oe;
    ce <= 1'b0;
    u_host.send(8'h3c);
    ce <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("freeze", held, sink.oe);
    u_host.send(8'hff);
    chk("freeze_dout", 8'h81, got);
    // Mid-run reset clears sinks, serial output and shift register
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    chk("rst", 8'h00, sink.oe | {7'h00, so});
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("rst_out", 8'h00, sink.oe | {7'h00, so});
    u_host.send(8'h00);
    chk("rst_dout", LSL_RESET_VAL, got);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
